// ---- sim/pcv_core_assertions.sv ----
// Purpose: Port checks for pcv_core
// Assumes: One clock, sync active-high reset
// Notes: Bound to every pcv_core at the foot of this file
module pcv_core_checker #(
  parameter PROG_BYTES = 32768
)
(
  input wire clk,
  input wire reset,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire [20:0] progAddr,
  input wire progRead,
  input wire [15:0] progData,
  input wire [15:0] instrWord,
  input wire irqHighReq,
  input wire irqLowReq,
  input wire wdtWake,
  input wire sleeping
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // Zero wait states, answer stands one cycle
  apb_ready_a: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("apb answer timing wrong");
  // Addresses past the map are refused
  err_map_a: assert property (pready |-> pslverr == (paddr > 8'h24 || paddr[1:0] != 2'h0))
    else $error("error response wrong");
  write_data_a: assert property (pready && pwrite |-> prdata == 32'h0)
    else $error("read data on a write");
  // Words past implemented memory read as zero
  fetch_zero_a: assert property (
    progRead |=> instrWord == (($past(progAddr) < PROG_BYTES) ? $past(progData) : 16'h0))
    else $error("fetched word wrong");
  // Steady fetch steps one word; register traffic may move pc
  fetch_step_a: assert property (
    progRead && $past(progRead) && !$past(pready) && !$past(pready, 2) && !$past(pready, 3)
    |-> progAddr == $past(progAddr) + 21'h2)
    else $error("fetch address step wrong");
  // Reset is checked outside the default disable
  reset_fetch_a: assert property (disable iff (1'b0) reset |=> !progRead && progAddr == 21'h0)
    else $error("fetch not at zero after reset");
  wake_exit_a: assert property (
    sleeping && (irqHighReq || irqLowReq || wdtWake) |=> !sleeping)
    else $error("no wake on request");
  sleep_idle_a: assert property (sleeping && $past(sleeping) |-> !progRead)
    else $error("fetch while asleep");
  wake_cov: cover property (sleeping ##1 !sleeping);
  zero_cov: cover property (progRead && progAddr >= PROG_BYTES);
  err_cov: cover property (pready && pslverr);
endmodule

bind pcv_core pcv_core_checker #(.PROG_BYTES(PROG_BYTES)) chkI (.clk(clk), .reset(reset), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .progAddr(progAddr), .progRead(progRead), .progData(progData), .instrWord(instrWord),
  .irqHighReq(irqHighReq), .irqLowReq(irqLowReq), .wdtWake(wdtWake), .sleeping(sleeping));

// ---- sim/pcv_prog_mem.sv ----
// Purpose: Program memory model for the fetch port
// Assumes: Combinational read of the shown address
// Notes: Idle bus shows inverted data so stale words never match
module pcv_prog_mem
(
  input wire [20:0] progAddr,
  input wire progRead,
  output logic [15:0] progData
);
  timeunit 1ns;
  timeprecision 1ps;
  // Separate fetch bus, answers beside register traffic
  assign progData = progRead ? (progAddr[15:0] ^ 16'ha5a5) : ~(progAddr[15:0] ^ 16'ha5a5);
endmodule

// ---- sim/tb.sv ----
// Purpose: Self-checking bench for pcv_core
// Assumes: Zero-wait APB slave, memory model on fetch port
// Notes: Small PROG_BYTES so fetch crosses the zero-fill edge
`include "pcv_regs.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PB = 64;
  logic clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, e;
  logic [7:0] paddr = 0, portPinIn = 8'hff, portPinOut, portPinOeN;
  logic [31:0] pwdata = 0, prdata, r;
  logic pready, pslverr, progRead, sleeping;
  logic irqHighReq = 0, irqLowReq = 0, wdtWake = 0;
  logic [20:0] progAddr;
  logic [15:0] progData, instrWord;
  int failures = 0, comparisons = 0;
  // 200 MHz clock
  always #2.5 clk = ~clk;
  pcv_core #(.PROG_BYTES(PB)) DUT (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .progAddr(progAddr), .progRead(progRead), .progData(progData), .instrWord(instrWord),
    .irqHighReq(irqHighReq), .irqLowReq(irqLowReq), .wdtWake(wdtWake), .sleeping(sleeping),
    .portPinIn(portPinIn), .portPinOut(portPinOut), .portPinOeN(portPinOeN));
  pcv_prog_mem MEM (.progAddr(progAddr), .progRead(progRead), .progData(progData));

  task automatic results();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    comparisons++;
    if (g !== x)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, x, g);
    end
  endtask

  // One transfer; request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    if (n == 16)
    begin
      failures++;
      results();
    end
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  // Bounded wait for the sleep state
  task automatic waitSleep(input logic v);
    int n;
    for (n = 0; n < 20 && sleeping !== v; n++)
      @(posedge clk);
    if (n == 20)
    begin
      failures++;
      results();
    end
  endtask

  // Reset, then reset values and an unmapped access
  task automatic tReset();
    logic [7:0] ad[6] = '{`PCV_OFF_CTRL, `PCV_OFF_PC, `PCV_OFF_SP, `PCV_OFF_DIR, `PCV_OFF_LATCH, `PCV_OFF_WAKE};
    logic [31:0] ex[6] = '{32'h10, 32'h0, 32'h0, 32'hbf, 32'h0, 32'h0};
    @(posedge clk);
    reset <= 1;
    repeat (10) @(posedge clk);
    reset <= 0;
    for (int i = 0; i < 6; i++)
    begin
      apb(0, ad[i], 0);
      chk("resetval", ex[i], r);
    end
    apb(0, 8'h40, 0);
    chk("unmapped", 32'h1, {31'h0, e});
  endtask

  // Run fetch past implemented memory with a read in mid-run
  task automatic tFetch();
    logic [20:0] a = 0;
    logic v = 0;
    apb(1, `PCV_OFF_CTRL, 32'h11);
    for (int i = 0; i < 60; i++)
    begin
      @(posedge clk);
      if (v)
        chk("instr", (a < PB) ? {16'h0, a[15:0] ^ 16'ha5a5} : 32'h0, {16'h0, instrWord});
      v = progRead;
      a = progAddr;
    end
    apb(0, `PCV_OFF_CTRL, 0);
    chk("ctrlrun", 32'h11, r);
    apb(1, `PCV_OFF_CTRL, 32'h10);
    apb(0, `PCV_OFF_PC, 0);
    chk("pceven", 32'h0, {r[31:21], 20'h0, r[0]});
  endtask

  // Sleep, wake by req, then flags, pc, pointer and stack top
  task automatic tWake(input logic [31:0] c, input logic [2:0] q, input logic [20:0] vec, input logic push);
    logic [31:0] p, s;
    apb(0, `PCV_OFF_PC, 0);
    p = r;
    apb(0, `PCV_OFF_SP, 0);
    s = r;
    apb(1, `PCV_OFF_CTRL, c | 32'h2);
    waitSleep(1);
    irqHighReq <= q[0];
    irqLowReq <= q[1];
    wdtWake <= q[2];
    waitSleep(0);
    irqHighReq <= 0;
    irqLowReq <= 0;
    wdtWake <= 0;
    apb(0, `PCV_OFF_WAKE, 0);
    chk("wake", {29'h0, q}, r);
    apb(0, `PCV_OFF_PC, 0);
    chk("pc", push ? {11'h0, vec} : p, r);
    apb(0, `PCV_OFF_SP, 0);
    chk("sp", s + push, r);
    apb(0, `PCV_OFF_TOS, 0);
    if (push)
      chk("tos", p, r);
    apb(1, `PCV_OFF_WAKE, 32'h7);
  endtask

  // Stack commands and top access; full and underflow reset the pc with the reset enable on
  task automatic tStack();
    apb(1, `PCV_OFF_SP, 32'h1e);
    apb(1, `PCV_OFF_CMD, 32'h1);
    apb(0, `PCV_OFF_SP, 0);
    chk("spfull", 32'h9f, r);
    apb(0, `PCV_OFF_TOS, 0);
    chk("pushtos", 32'h18, r);
    apb(0, `PCV_OFF_PC, 0);
    chk("pcfull", 32'h0, r);
    apb(1, `PCV_OFF_TOS, 32'h1234);
    apb(1, `PCV_OFF_CMD, 32'h4);
    apb(0, `PCV_OFF_PC, 0);
    chk("pcret", 32'h1234, r);
    apb(0, `PCV_OFF_SP, 0);
    chk("spret", 32'h9e, r);
    apb(1, `PCV_OFF_SP, 32'h0);
    apb(1, `PCV_OFF_CMD, 32'h2);
    apb(0, `PCV_OFF_SP, 0);
    chk("spunder", 32'h40, r);
    apb(0, `PCV_OFF_PC, 0);
    chk("pcunder", 32'h0, r);
  endtask

  // Shared pin bit 6 in every oscillator mode; latch and dir rewritten, a masked bit is lost
  task automatic tPort();
    logic [7:0] m6;
    for (int m = 0; m < 8; m++)
    begin
      m6 = (m == 5 || m == 6) ? 8'h40 : 8'h00;
      portPinIn <= 8'h40 | m[7:0];
      apb(1, `PCV_OFF_CTRL, 32'h10 | (m << 8));
      apb(1, `PCV_OFF_LATCH, 32'hff);
      apb(1, `PCV_OFF_DIR, 32'h0f);
      apb(0, `PCV_OFF_LATCH, 0);
      chk("latch", {24'h0, 8'hbf | m6}, r);
      apb(0, `PCV_OFF_PINS, 0);
      chk("pins", {24'h0, (8'h40 | m[7:0]) & (8'hbf | m6)}, r);
      chk("pinout", {24'h0, 8'hbf | m6}, {24'h0, portPinOut});
      chk("pinoen", {24'h0, 8'h0f | (m6 ^ 8'h40)}, {24'h0, portPinOeN});
    end
  endtask

  initial
  begin
    tReset();
    tFetch();
    tWake(32'h14, 3'b001, 21'h8, 1);
    tWake(32'h18, 3'b010, 21'h18, 1);
    tWake(32'h1c, 3'b100, 21'h0, 0);
    tWake(32'h10, 3'b001, 21'h0, 0);
    tStack();
    tPort();
    tReset();
    results();
  end
endmodule

// ---- verilog/pcv_core.v ----
// Purpose: Program counter, reset and interrupt vectoring, sleep wake-up
// Assumes: Interrupt and watchdog requests come from logic on clk
// Notes: APB slave with zero wait states; fetch runs beside it
// Notes on behaviour
// RL1: Program counter is 21 bits, covering a 2-Mbyte program space.
// RL2: Every reset restarts fetching at address zero.
// RL3: High priority vector sits at 0008h, low priority at 0018h.
// RL4: Interrupt wake with matching global enable loads the matching vector.
// RL5: Same wake pushes the current program counter onto the return stack top.
// RL6: Same wake advances the stack pointer to the next stack slot.
// RL7: Any interrupt or watchdog wake sets at least one wake flag.
// RL8: Port bit 6 works only in the two pin-freeing oscillator modes, else zero.
// RL9: Fetch and register accesses use separate buses and may coincide.
// RL10: Fetch above implemented memory returns zero, executing as no-op.
// RL11: A push increments the 5-bit pointer first, then writes the slot.
//
// The APB register port and the register offsets are this design's own decisions.
`include "pcv_regs.vh"

module pcv_core #(
  parameter PROG_BYTES = 32768,
  parameter STACK_DEPTH = 31
)
(
  input wire clk,
  input wire reset,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  output wire [20:0] progAddr,
  output wire progRead,
  input wire [15:0] progData,
  output wire [15:0] instrWord,
  input wire irqHighReq,
  input wire irqLowReq,
  input wire wdtWake,
  output reg sleeping,
  input wire [7:0] portPinIn,
  output reg [7:0] portPinOut,
  output reg [7:0] portPinOeN
);

  // Pin 6 is only usable when the oscillator leaves it free
  function [7:0] portMask;
    input [2:0] oscMode;
    begin
      portMask = 8'hff;
      if (oscMode != `PCV_OSC_EXT_FREED && oscMode != `PCV_OSC_RC_FREED)
        portMask[`PCV_FREED_BIT] = 1'b0;
    end
  endfunction

  reg [20:0] pc;
  reg [10:0] ctrl;
  reg [2:0] wakeFlags;
  reg [7:0] portLatch;
  reg [7:0] portDir;
  reg [7:0] pinSync1;
  reg [7:0] pinSync2;
  reg [31:0] next_prdata;
  reg next_pslverr;

  wire [2:0] oscMode;
  wire [7:0] pinMask;
  wire wrEdge;
  wire setupPhase;
  wire wake;
  wire vectorHigh;
  wire vectorLow;
  wire ctrlWr;
  wire wakeWr;
  wire spWr;
  wire tosWr;
  wire cmdWr;
  wire pushReq;
  wire popReq;
  wire retReq;
  wire [4:0] stackPtr;
  wire [20:0] topWord;
  wire [20:0] popWord;
  wire fullFlag;
  wire underFlag;
  wire stackReset;
  wire fetchEn;

  assign oscMode = ctrl[`PCV_CTRL_OSC_HI:`PCV_CTRL_OSC_LO];
  assign pinMask = portMask(oscMode);

  // Writes land only at the access edge the master sees pready high
  assign setupPhase = psel && !penable;
  assign wrEdge = psel && penable && pready && pwrite;
  assign ctrlWr = wrEdge && (paddr == `PCV_OFF_CTRL);
  assign wakeWr = wrEdge && (paddr == `PCV_OFF_WAKE);
  assign spWr = wrEdge && (paddr == `PCV_OFF_SP);
  assign tosWr = wrEdge && (paddr == `PCV_OFF_TOS);
  assign cmdWr = wrEdge && (paddr == `PCV_OFF_CMD);

  // Wake sources; high priority outranks low when both arrive together
  assign wake = sleeping && (irqHighReq || irqLowReq || wdtWake);
  assign vectorHigh = wake && irqHighReq && ctrl[`PCV_CTRL_HIGH_PRIORITY_GLOBAL_IRQ_ENABLE];
  assign vectorLow = wake && !vectorHigh && irqLowReq && ctrl[`PCV_CTRL_LOW_PRIORITY_GLOBAL_IRQ_ENABLE];

  // Hardware push outranks a software stack command in the same cycle
  assign pushReq = vectorHigh || vectorLow || (cmdWr && pwdata[`PCV_CMD_PUSH]); // [RL5] [RL6]
  assign popReq = !pushReq && cmdWr && (pwdata[`PCV_CMD_POP] || pwdata[`PCV_CMD_RET]);
  assign retReq = popReq && pwdata[`PCV_CMD_RET];

  // Fetch keeps going while software uses the register bus
  assign fetchEn = ctrl[`PCV_CTRL_RUN] && !sleeping; // [RL9]

  pcv_return_stack #(
    .DEPTH(STACK_DEPTH)
  ) u_stack (
    .clk(clk),
    .reset(reset),
    .push(pushReq),
    .pop(popReq),
    .pushData(pc), // [RL5]
    .tosWrite(tosWr),
    .tosData(pwdata[20:0]),
    .spWrite(spWr),
    .spData(pwdata[4:0]),
    .clearFull(spWr && !pwdata[`PCV_SP_FULL]),
    .clearUnder(spWr && !pwdata[`PCV_SP_UNDER]),
    .overflowResetEn(ctrl[`PCV_CTRL_STVR]),
    .stackPtr(stackPtr),
    .topWord(topWord),
    .popWord(popWord),
    .fullFlag(fullFlag),
    .underFlag(underFlag),
    .stackReset(stackReset)
  );

  pcv_prog_fetch #(
    .PROG_BYTES(PROG_BYTES)
  ) u_fetch (
    .clk(clk),
    .reset(reset),
    .fetchEn(fetchEn),
    .pc(pc),
    .progData(progData),
    .progAddr(progAddr),
    .progRead(progRead),
    .instrWord(instrWord)
  );

  // Program counter: reset vector, interrupt vectors, returns, stepping
  always @(posedge clk)
  begin
    if (reset || stackReset)
    begin
      pc <= `PCV_RESET_VECTOR; // [RL2] [RL1]
    end
    else if (vectorHigh)
    begin
      pc <= `PCV_HIGH_VECTOR; // [RL3] [RL4] [RL6]
    end
    else if (vectorLow)
    begin
      pc <= `PCV_LOW_VECTOR; // [RL3] [RL4] [RL6]
    end
    else if (retReq)
    begin
      pc <= popWord;
    end
    else if (fetchEn)
    begin
      pc <= pc + `PCV_PC_STEP; // Wraps within the 2-Mbyte space
    end
  end

  // Sleep state; the sleep bit is a command, not a stored level
  always @(posedge clk)
  begin
    if (reset || stackReset)
    begin
      sleeping <= 1'b0;
    end
    else if (wake)
    begin
      sleeping <= 1'b0;
    end
    else if (ctrlWr && pwdata[`PCV_CTRL_SLEEP])
    begin
      sleeping <= 1'b1;
    end
  end

  // Control register
  always @(posedge clk)
  begin
    if (reset)
    begin
      ctrl <= `PCV_CTRL_RESET;
    end
    else if (ctrlWr)
    begin
      ctrl <= pwdata[10:0] & 11'h71d; // Sleep bit never stored
    end
  end

  // Wake flags: sticky, write one to clear, a new wake beats the clear
  always @(posedge clk)
  begin
    if (reset)
    begin
      wakeFlags <= 3'h0;
    end
    else
    begin
      wakeFlags[`PCV_WAKE_HIGH] <= (wake && irqHighReq) ||
        (wakeFlags[`PCV_WAKE_HIGH] && !(wakeWr && pwdata[`PCV_WAKE_HIGH])); // [RL7]
      wakeFlags[`PCV_WAKE_LOW] <= (wake && irqLowReq) ||
        (wakeFlags[`PCV_WAKE_LOW] && !(wakeWr && pwdata[`PCV_WAKE_LOW])); // [RL7]
      wakeFlags[`PCV_WAKE_WDT] <= (wake && wdtWake) ||
        (wakeFlags[`PCV_WAKE_WDT] && !(wakeWr && pwdata[`PCV_WAKE_WDT])); // [RL7]
    end
  end

  // Port latch and direction; bit 6 forced clear unless the pin is freed
  always @(posedge clk)
  begin
    if (reset)
    begin
      portLatch <= `PCV_LATCH_RESET;
      portDir <= `PCV_DIR_RESET;
    end
    else
    begin
      if (wrEdge && paddr == `PCV_OFF_LATCH)
        portLatch <= pwdata[7:0] & pinMask; // [RL8]
      else
        portLatch <= portLatch & pinMask; // [RL8]
      if (wrEdge && paddr == `PCV_OFF_DIR)
        portDir <= pwdata[7:0] & pinMask; // [RL8]
      else
        portDir <= portDir & pinMask; // [RL8]
    end
  end

  // Pin drivers from flops; a disabled pin 6 is never driven
  always @(posedge clk)
  begin
    if (reset)
    begin
      portPinOut <= 8'h00;
      portPinOeN <= 8'hff;
    end
    else
    begin
      portPinOut <= portLatch & pinMask;
      portPinOeN <= portDir | ~pinMask; // [RL8]
    end
  end

  // Pins are asynchronous; two flops before anything reads them
  always @(posedge clk)
  begin
    if (reset)
    begin
      pinSync1 <= 8'h00;
      pinSync2 <= 8'h00;
    end
    else
    begin
      pinSync1 <= portPinIn;
      pinSync2 <= pinSync1;
    end
  end

  // Read mux, evaluated in the setup cycle
  always @*
  begin
    next_prdata = 32'h00000000;
    next_pslverr = 1'b0;
    case (paddr)
      `PCV_OFF_CTRL: next_prdata = {21'h000000, ctrl};
      `PCV_OFF_WAKE: next_prdata = {29'h00000000, wakeFlags};
      `PCV_OFF_PC: next_prdata = {11'h000, pc};
      `PCV_OFF_SP: next_prdata = {24'h000000, fullFlag, underFlag, 1'b0, stackPtr};
      `PCV_OFF_TOS: next_prdata = {11'h000, topWord};
      `PCV_OFF_CMD: next_prdata = 32'h00000000;
      `PCV_OFF_PINS: next_prdata = {24'h000000, pinSync2 & pinMask}; // [RL8]
      `PCV_OFF_LATCH: next_prdata = {24'h000000, portLatch};
      `PCV_OFF_DIR: next_prdata = {24'h000000, portDir};
      `PCV_OFF_INSTR: next_prdata = {16'h0000, instrWord};
      default: next_pslverr = 1'b1;
    endcase
  end

  // APB answer: one access cycle, zero wait states
  always @(posedge clk)
  begin
    if (reset)
    begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else if (setupPhase)
    begin
      prdata <= pwrite ? 32'h00000000 : next_prdata;
      pready <= 1'b1;
      pslverr <= next_pslverr;
    end
    else
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

endmodule

// ---- verilog/pcv_prog_fetch.v ----
// Purpose: Program memory fetch port with out-of-range zero fill
// Assumes: Memory answers combinationally for the address it is shown
// Notes: Words past the implemented size come back as zero, a no-op
`include "pcv_regs.vh"

module pcv_prog_fetch #(
  parameter PROG_BYTES = 32768
)
(
  input wire clk,
  input wire reset,
  input wire fetchEn,
  input wire [20:0] pc,
  input wire [15:0] progData,
  output reg [20:0] progAddr,
  output reg progRead,
  output reg [15:0] instrWord
);

  // Implemented range check, shared by every fetch
  function inRange;
    input [20:0] addr;
    begin
      inRange = ({11'h000, addr} < PROG_BYTES);
    end
  endfunction

  reg addrInRange;

  // Address goes out one cycle, the word is captured the next
  always @(posedge clk)
  begin
    if (reset)
    begin
      progAddr <= `PCV_RESET_VECTOR;
      progRead <= 1'b0;
      addrInRange <= 1'b0;
      instrWord <= 16'h0000;
    end
    else
    begin
      progRead <= fetchEn;
      if (fetchEn)
      begin
        progAddr <= pc;
        addrInRange <= inRange(pc);
      end
      if (progRead)
      begin
        instrWord <= addrInRange ? progData : 16'h0000; // [RL10]
      end
    end
  end

endmodule

// ---- verilog/pcv_regs.vh ----
// Purpose: Shared constants of the program counter and vectoring block
// Assumes: APB byte addresses, 32-bit data, one register per word
// Notes: Offsets of the register map and the control, stack pointer and port register reset values live here
`ifndef PCV_REGS_VH
`define PCV_REGS_VH

// Program counter and fixed vectors
`define PCV_PC_W 21
`define PCV_RESET_VECTOR 21'h000000
`define PCV_HIGH_VECTOR 21'h000008
`define PCV_LOW_VECTOR 21'h000018
`define PCV_PC_STEP 21'h000002

// Return stack geometry
`define PCV_SP_W 5
`define PCV_SP_TOP 5'h1f
`define PCV_SP_RESET 5'h00

// Register offsets
`define PCV_OFF_CTRL 8'h00
`define PCV_OFF_WAKE 8'h04
`define PCV_OFF_PC 8'h08
`define PCV_OFF_SP 8'h0c
`define PCV_OFF_TOS 8'h10
`define PCV_OFF_CMD 8'h14
`define PCV_OFF_PINS 8'h18
`define PCV_OFF_LATCH 8'h1c
`define PCV_OFF_DIR 8'h20
`define PCV_OFF_INSTR 8'h24

// Control register fields
`define PCV_CTRL_RUN 0
`define PCV_CTRL_SLEEP 1
`define PCV_CTRL_HIGH_PRIORITY_GLOBAL_IRQ_ENABLE 2
`define PCV_CTRL_LOW_PRIORITY_GLOBAL_IRQ_ENABLE 3
`define PCV_CTRL_STVR 4
`define PCV_CTRL_OSC_LO 8
`define PCV_CTRL_OSC_HI 10
`define PCV_CTRL_RESET 11'h010

// Oscillator modes that free the shared port pin
`define PCV_OSC_EXT_FREED 3'h5
`define PCV_OSC_RC_FREED 3'h6
`define PCV_FREED_BIT 6

// Wake flag fields
`define PCV_WAKE_HIGH 0
`define PCV_WAKE_LOW 1
`define PCV_WAKE_WDT 2

// Stack pointer register fields
`define PCV_SP_FULL 7
`define PCV_SP_UNDER 6

// Stack command fields
`define PCV_CMD_PUSH 0
`define PCV_CMD_POP 1
`define PCV_CMD_RET 2

// Port reset values (all inputs, latch clear)
`define PCV_DIR_RESET 8'hff
`define PCV_LATCH_RESET 8'h00

`endif

// ---- verilog/pcv_return_stack.v ----
// Purpose: 31-deep by 21-bit hardware return stack with 5-bit pointer
// Assumes: At most one of push, pop in a cycle; the caller arbitrates
// Notes: Slot 0 holds no data, it is only the empty position
`include "pcv_regs.vh"

module pcv_return_stack #(
  parameter DEPTH = 31
)
(
  input wire clk,
  input wire reset,
  input wire push,
  input wire pop,
  input wire [20:0] pushData,
  input wire tosWrite,
  input wire [20:0] tosData,
  input wire spWrite,
  input wire [4:0] spData,
  input wire clearFull,
  input wire clearUnder,
  input wire overflowResetEn,
  output reg [4:0] stackPtr,
  output wire [20:0] topWord,
  output wire [20:0] popWord,
  output reg fullFlag,
  output reg underFlag,
  output reg stackReset
);

  reg [20:0] slots [0:31];
  wire [4:0] nextPtr;
  wire atTop;
  wire atEmpty;

  assign nextPtr = stackPtr + 5'h01;
  assign atTop = (stackPtr == DEPTH[4:0]);
  assign atEmpty = (stackPtr == `PCV_SP_RESET);
  // Empty slot reads zero, so an underflow return lands on the reset vector
  assign topWord = atEmpty ? `PCV_RESET_VECTOR : slots[stackPtr];
  assign popWord = topWord;

  // Pointer moves first, then the addressed slot takes the pushed word
  always @(posedge clk)
  begin
    stackReset <= 1'b0;
    if (reset)
    begin
      stackPtr <= `PCV_SP_RESET;
    end
    else if (push)
    begin
      if (atTop)
      begin
        slots[stackPtr] <= pushData; // Overwrites the last slot
      end
      else
      begin
        stackPtr <= nextPtr; // [RL11]
        slots[nextPtr] <= pushData; // [RL11]
        if (nextPtr == DEPTH[4:0] && overflowResetEn)
        begin
          stackReset <= 1'b1;
        end
      end
    end
    else if (pop)
    begin
      if (atEmpty)
      begin
        stackReset <= overflowResetEn;
      end
      else
      begin
        stackPtr <= stackPtr - 5'h01;
      end
    end
    else if (tosWrite && !atEmpty)
    begin
      slots[stackPtr] <= tosData;
    end
    else if (spWrite)
    begin
      stackPtr <= spData;
    end
  end

  // Sticky flags; a new event wins over a software clear in the same cycle
  always @(posedge clk)
  begin
    if (reset)
    begin
      fullFlag <= 1'b0;
      underFlag <= 1'b0;
    end
    else
    begin
      if (push && (atTop || nextPtr == DEPTH[4:0]))
        fullFlag <= 1'b1;
      else if (clearFull)
        fullFlag <= 1'b0;
      if (pop && atEmpty)
        underFlag <= 1'b1;
      else if (clearUnder)
        underFlag <= 1'b0;
    end
  end

endmodule
